// *** design/csa_defines.svh ***
// Opcodes, encodings and beat count for the snoop response agent
`ifndef CSA_DEFINES_SVH
`define CSA_DEFINES_SVH

// Host-to-device response opcodes (4 bits)
`define CSA_OP_PULL          4'h1
`define CSA_OP_GLOBAL_OBS    4'h4
`define CSA_OP_OBS_PULL      4'h5
`define CSA_OP_SYS_CMP       4'h6
`define CSA_OP_OBS_DISCARD   4'h8
`define CSA_OP_LOCAL_OBS     4'hC
`define CSA_OP_LOCAL_PULL    4'hD
`define CSA_OP_ERR_PULL      4'hF

// Host snoop opcodes (3 bits)
`define CSA_SNP_SHARED       3'h1
`define CSA_SNP_OWN          3'h2
`define CSA_SNP_CUR          3'h3

// MESI codes carried in the response data field of a global observation
`define CSA_MESI_I           4'h3
`define CSA_MESI_S           4'h1
`define CSA_MESI_E           4'h2
`define CSA_MESI_M           4'h6
`define CSA_MESI_ERR         4'h4

// Snoop reply opcodes (5 bits)
`define CSA_RSP_IHITI        5'h04
`define CSA_RSP_VHITV        5'h06
`define CSA_RSP_IHITSE       5'h05
`define CSA_RSP_SHITSE       5'h01
`define CSA_RSP_SFWDM        5'h07
`define CSA_RSP_IFWDM        5'h0F
`define CSA_RSP_VFWDV        5'h16

// Data beats per 64 byte line (two 32 byte halves)
`define CSA_BEATS            2

`endif

// *** design/csa_pkg.sv ***
// Types shared by the snoop response agent files
package csa_pkg;

    typedef enum logic [1:0] {
        CSA_ST_I = 2'h0,
        CSA_ST_S = 2'h1,
        CSA_ST_E = 2'h2,
        CSA_ST_M = 2'h3
    } csa_mesi_t;

    // Host snoop request
    typedef struct packed {
        logic        valid;
        logic [2:0]  op;
        logic [11:0] tag;
        logic [45:0] addr;
    } csa_snoop_t;

    // Host response to a device request
    typedef struct packed {
        logic        valid;
        logic [3:0]  op;
        logic [11:0] data;
        logic [11:0] req_id;
    } csa_h2d_rsp_t;

    // Device snoop reply
    typedef struct packed {
        logic        valid;
        logic [4:0]  op;
        logic [11:0] tag;
    } csa_d2h_rsp_t;

    // Device data beat
    typedef struct packed {
        logic         valid;
        logic [11:0]  tag;
        logic         stale;
        logic [31:0]  byte_en;
        logic [255:0] data;
    } csa_d2h_data_t;

    // Events reported to the device core
    typedef struct packed {
        logic        valid;
        logic [11:0] req_id;
        logic        observed;
        logic        sys_done;
        logic        use_once;
        logic        error;
        logic        drop_mod;
        csa_mesi_t   state;
    } csa_event_t;

endpackage

// *** design/csa_line_slot.sv ***
// One tracked cache line: address, state, data and evict bookkeeping
`timescale 1ns/1ps
module csa_line_slot
    import csa_pkg::*;
#(
    parameter int AW = 46,
    parameter int LW = 512
) (
    // Clock and control
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic            ce,
    // Writes from the agent
    input  wire logic            wr_en,
    input  wire logic [AW-1:0]   wr_addr,
    input  wire csa_mesi_t       wr_state,
    input  wire logic            wr_data_en,
    input  wire logic [LW-1:0]   wr_data,
    input  wire logic            evict_set,
    input  wire logic            evict_obs,
    input  wire logic            evict_pull,
    input  wire logic            snoop_hit,
    // Slot contents
    output logic [AW-1:0]        addr,
    output csa_mesi_t            state,
    output logic [LW-1:0]        data,
    output logic                 evict_busy,
    output logic                 stale
);
    `include "csa_defines.svh"

    logic obs_seen_r;
    logic pull_seen_r;

    // Line address, state and data
    always_ff @(posedge clock) begin
        if (rst) begin
            addr  <= '0;
            state <= CSA_ST_I;
            data  <= '0;
        end else if (ce) begin
            if (wr_en) begin
                addr  <= wr_addr;
                state <= wr_state;
            end
            if (wr_data_en)
                data <= wr_data;
        end
    end

    // Evict stays busy until both observation and pull are seen
    always_ff @(posedge clock) begin
        if (rst) begin
            evict_busy  <= 1'b0;
            obs_seen_r  <= 1'b0;
            pull_seen_r <= 1'b0;
            stale       <= 1'b0;
        end else if (ce) begin
            if (evict_set) begin
                evict_busy  <= 1'b1;
                obs_seen_r  <= 1'b0;
                pull_seen_r <= 1'b0;
                stale       <= 1'b0;
            end else if (evict_busy) begin
                if (evict_obs)
                    obs_seen_r <= 1'b1;
                if (evict_pull)
                    pull_seen_r <= 1'b1;
                // Snoop hit before the pull marks later data stale
                if (snoop_hit && !pull_seen_r)
                    stale <= 1'b1;
                if ((obs_seen_r || evict_obs) &&
                    (pull_seen_r || evict_pull))
                    evict_busy <= 1'b0;
            end
        end
    end

endmodule

// *** design/csa_agent.sv ***
// Device-side coherent cache snoop and response agent
// ------
// Functional notes
// - Shared snoop invalidates or downgrades, returns dirty
// - Ownership snoop invalidates, returns dirty data
// - Current-copy snoop returns Modified line, keeps state
// - Four-bit response opcode, data field tag or MESI
// - Pull sends write data, state unchanged
// - Global observation installs the encoded MESI state
// - Modified grant keeps line until written back
// - Invalid or Error observation: use once, never cache
// - Error on read or cacheable write drops data
// - Observe-and-pull marks observed and sends data
// - System completion confirms full system visibility
// - Discard variant completes without sending data
// - Local observation may be ignored, await completion
// - Local observe-and-pull always sends data
// - Error observe-and-pull sends data, state Error
// - Snoop after observation uses new state
// - Snoop hitting pending evict marks data stale
// - No second evict until observation and pull
// - Every snoop gets a snoop reply
// - Snoop data carries all byte enables set
// ------
`timescale 1ns/1ps
module csa_agent
    import csa_pkg::*;
#(
    parameter int SLOTS = 4,
    parameter int AW    = 46,
    parameter int LW    = 512
) (
    // Clock and control
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic            ce,
    // Host messages
    input  wire csa_snoop_t      snoop_in,
    input  wire csa_h2d_rsp_t    h2d_rsp_in,
    // Device core: request tracking in slot req_id
    input  wire logic            core_req,
    input  wire logic [11:0]     core_req_id,
    input  wire logic [AW-1:0]   core_addr,
    input  wire logic            core_evict,
    input  wire logic            core_cacheable,
    input  wire logic [LW-1:0]   core_wdata,
    input  wire logic            core_fill,
    input  wire logic [LW-1:0]   core_fill_data,
    input  wire logic            core_fast_obs,
    // Outputs to the host
    output csa_d2h_rsp_t         d2h_rsp_out,
    output csa_d2h_data_t        d2h_data_out,
    // Outputs to the device core
    output csa_event_t           event_out,
    output logic                 evict_refused_r,
    output logic                 busy_r
);
    `include "csa_defines.svh"

    localparam int IW = $clog2(SLOTS);

    initial begin
        if (SLOTS < 2 || LW != 256 * `CSA_BEATS)
            $error("csa_agent: unsupported SLOTS or LW");
    end

    // ------
    // Slot array
    // ------
    logic [AW-1:0] s_addr   [SLOTS];
    csa_mesi_t     s_state  [SLOTS];
    logic [LW-1:0] s_data   [SLOTS];
    logic          s_ebusy  [SLOTS];
    logic          s_stale  [SLOTS];
    logic [SLOTS-1:0] wr_en, wd_en, ev_set, ev_obs, ev_pull, s_hit;
    csa_mesi_t     wr_state;
    logic [LW-1:0] wr_data;
    logic [AW-1:0] wr_addr;

    for (genvar g = 0; g < SLOTS; g++) begin : g_slot
        csa_line_slot #(.AW(AW), .LW(LW)) u_slot (
            .clock      (clock),
            .rst        (rst),
            .ce         (ce),
            .wr_en      (wr_en[g]),
            .wr_addr    (wr_addr),
            .wr_state   (wr_state),
            .wr_data_en (wd_en[g]),
            .wr_data    (wr_data),
            .evict_set  (ev_set[g]),
            .evict_obs  (ev_obs[g]),
            .evict_pull (ev_pull[g]),
            .snoop_hit  (s_hit[g]),
            .addr       (s_addr[g]),
            .state      (s_state[g]),
            .data       (s_data[g]),
            .evict_busy (s_ebusy[g]),
            .stale      (s_stale[g])
        );
    end

    // Per-slot request attributes
    logic [SLOTS-1:0] cacheable_r;
    logic [SLOTS-1:0] wait_cmp_r;

    // ------
    // Snoop lookup
    // ------
    logic          snp_hit;
    logic [IW-1:0] snp_idx;
    always_comb begin
        snp_hit = 1'b0;
        snp_idx = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (!snp_hit && s_addr[i] == snoop_in.addr &&
                (s_state[i] != CSA_ST_I || s_ebusy[i])) begin
                snp_hit = 1'b1;
                snp_idx = IW'(i);
            end
        end
    end

    // Data sender state
    typedef enum logic [2:0] {
        CSA_DS_IDLE = 3'b001,
        CSA_DS_LOW  = 3'b010,
        CSA_DS_HIGH = 3'b100
    } csa_ds_t;
    csa_ds_t       ds_r;
    logic [LW-1:0] line_r;
    logic [11:0]   dtag_r;
    logic          dstale_r;

    // Response decode
    logic          rsp_v;
    logic [IW-1:0] rid;
    logic          is_pull;
    logic          send_pull;
    assign rsp_v = h2d_rsp_in.valid && !ds_r[2] && !ds_r[1];
    assign rid   = h2d_rsp_in.req_id[IW-1:0];
    // Pull-type responses: all but discard send data; error still sends
    assign is_pull = h2d_rsp_in.op == `CSA_OP_PULL ||
                     h2d_rsp_in.op == `CSA_OP_OBS_PULL ||
                     h2d_rsp_in.op == `CSA_OP_OBS_DISCARD ||
                     h2d_rsp_in.op == `CSA_OP_LOCAL_PULL ||
                     h2d_rsp_in.op == `CSA_OP_ERR_PULL;
    assign send_pull = is_pull &&
                       h2d_rsp_in.op != `CSA_OP_OBS_DISCARD;

    // Observation MESI decode
    function automatic csa_mesi_t mesi_of(input logic [3:0] c);
        case (c)
            `CSA_MESI_M: mesi_of = CSA_ST_M;
            `CSA_MESI_E: mesi_of = CSA_ST_E;
            `CSA_MESI_S: mesi_of = CSA_ST_S;
            default:     mesi_of = CSA_ST_I;
        endcase
    endfunction

    // ------
    // Slot write steering
    // ------
    // Host ordering keeps snoops and responses off one line, so
    // they share the write port: a core request has it first, then
    // a snoop, then a response.
    logic snp_v;
    assign snp_v = snoop_in.valid && ds_r[0];
    always_comb begin
        wr_en    = '0;
        wd_en    = '0;
        ev_set   = '0;
        ev_obs   = '0;
        ev_pull  = '0;
        s_hit    = '0;
        wr_state = CSA_ST_I;
        wr_data  = core_fill_data;
        wr_addr  = s_addr[rid];
        if (ce && core_req) begin
            wr_en[core_req_id[IW-1:0]] = 1'b1;
            wr_addr  = core_addr;
            wr_state = s_state[core_req_id[IW-1:0]];
            if (core_evict && !s_ebusy[core_req_id[IW-1:0]]) begin
                ev_set[core_req_id[IW-1:0]] = 1'b1;
                wd_en[core_req_id[IW-1:0]]  = 1'b1;
                wr_data = core_wdata;
            end
        end else if (ce && snp_v && snp_hit) begin
            wr_en[snp_idx] = 1'b1;
            wr_addr = s_addr[snp_idx];
            s_hit[snp_idx] = s_ebusy[snp_idx];
            // Shared snoop downgrades, ownership snoop invalidates
            case (snoop_in.op)
                `CSA_SNP_SHARED: wr_state = (s_state[snp_idx] == CSA_ST_I)
                                  ? CSA_ST_I : CSA_ST_S;
                `CSA_SNP_OWN:    wr_state = CSA_ST_I;
                default:         wr_state = s_state[snp_idx];
            endcase
        end else if (ce && rsp_v) begin
            if (h2d_rsp_in.op == `CSA_OP_GLOBAL_OBS) begin
                wr_en[rid] = 1'b1;
                ev_obs[rid] = 1'b1;
                // I or Error: data used once and never cached
                wr_state = (s_ebusy[rid]) ? CSA_ST_I
                         : mesi_of(h2d_rsp_in.data[3:0]);
            end else if (is_pull) begin
                ev_pull[rid] = 1'b1;
                if (h2d_rsp_in.op != `CSA_OP_PULL)
                    ev_obs[rid] = 1'b1;
            end
        end
        if (ce && core_fill && !core_req)
            wd_en[core_req_id[IW-1:0]] = 1'b1;
    end

    // ------
    // Snoop reply channel
    // ------
    // A snoop taken while the sender is idle is answered the next cycle from the current state, which
    // already reflects any earlier observation.
    always_ff @(posedge clock) begin
        if (rst) begin
            d2h_rsp_out <= '0;
        end else if (ce) begin
            d2h_rsp_out.valid <= snp_v;
            d2h_rsp_out.tag   <= snoop_in.tag;
            if (!snp_hit || s_state[snp_idx] == CSA_ST_I)
                d2h_rsp_out.op <= `CSA_RSP_IHITI;
            else if (s_state[snp_idx] == CSA_ST_M)
                case (snoop_in.op)
                    `CSA_SNP_SHARED: d2h_rsp_out.op <= `CSA_RSP_SFWDM;
                    `CSA_SNP_OWN:    d2h_rsp_out.op <= `CSA_RSP_IFWDM;
                    default:         d2h_rsp_out.op <= `CSA_RSP_VFWDV;
                endcase
            else
                case (snoop_in.op)
                    `CSA_SNP_SHARED: d2h_rsp_out.op <= `CSA_RSP_SHITSE;
                    `CSA_SNP_OWN:    d2h_rsp_out.op <= `CSA_RSP_IHITSE;
                    default:         d2h_rsp_out.op <= `CSA_RSP_VHITV;
                endcase
        end
    end

    // ------
    // Data channel: two 32 byte beats, lower half first
    // ------
    // While a line is going out, new snoops and responses are not
    // consumed; the host must hold them, a small loss of throughput
    // traded for a sender that holds a single line.
    always_ff @(posedge clock) begin
        if (rst) begin
            ds_r     <= CSA_DS_IDLE;
            line_r   <= '0;
            dtag_r   <= '0;
            dstale_r <= 1'b0;
        end else if (ce) begin
            case (ds_r)
                CSA_DS_IDLE: begin
                    if (snp_v && snp_hit && s_state[snp_idx] == CSA_ST_M)
                    begin
                        ds_r     <= CSA_DS_LOW;
                        line_r   <= s_data[snp_idx];
                        dtag_r   <= snoop_in.tag;
                        dstale_r <= 1'b0;
                    end else if (!(snp_v && snp_hit) && rsp_v && send_pull)
                    begin
                        ds_r     <= CSA_DS_LOW;
                        line_r   <= s_data[rid];
                        dtag_r   <= h2d_rsp_in.data;
                        dstale_r <= s_stale[rid] ||
                                    (s_ebusy[rid] && snp_hit &&
                                     snp_idx == rid);
                    end
                end
                CSA_DS_LOW:  ds_r <= CSA_DS_HIGH;
                CSA_DS_HIGH: ds_r <= CSA_DS_IDLE;
                default:     ds_r <= CSA_DS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            d2h_data_out <= '0;
        end else if (ce) begin
            d2h_data_out.valid   <= ds_r[1] || ds_r[2];
            d2h_data_out.tag     <= dtag_r;
            d2h_data_out.stale   <= dstale_r;
            d2h_data_out.byte_en <= '1;
            d2h_data_out.data    <= ds_r[1] ? line_r[255:0]
                                            : line_r[LW-1:256];
        end
    end

    // ------
    // Events to the device core
    // ------
    always_ff @(posedge clock) begin
        if (rst) begin
            event_out   <= '0;
            cacheable_r <= '0;
            wait_cmp_r  <= '0;
        end else if (ce) begin
            event_out       <= '0;
            event_out.req_id <= h2d_rsp_in.req_id;
            if (core_req)
                cacheable_r[core_req_id[IW-1:0]] <= core_cacheable;
            if (rsp_v && !(snp_v && snp_hit)) begin
                case (h2d_rsp_in.op)
                    `CSA_OP_GLOBAL_OBS: begin
                        event_out.valid    <= 1'b1;
                        event_out.observed <= 1'b1;
                        event_out.state    <= mesi_of(h2d_rsp_in.data[3:0]);
                        event_out.use_once <=
                            mesi_of(h2d_rsp_in.data[3:0]) == CSA_ST_I;
                        event_out.error <=
                            h2d_rsp_in.data[3:0] == `CSA_MESI_ERR;
                        event_out.drop_mod <=
                            h2d_rsp_in.data[3:0] == `CSA_MESI_ERR &&
                            cacheable_r[rid];
                    end
                    `CSA_OP_OBS_PULL, `CSA_OP_OBS_DISCARD: begin
                        event_out.valid    <= 1'b1;
                        event_out.observed <= 1'b1;
                    end
                    `CSA_OP_LOCAL_OBS, `CSA_OP_LOCAL_PULL: begin
                        // Without fast observation wait for completion
                        event_out.valid    <= core_fast_obs;
                        event_out.observed <= core_fast_obs;
                        wait_cmp_r[rid]    <= 1'b1;
                    end
                    `CSA_OP_ERR_PULL: begin
                        event_out.valid    <= 1'b1;
                        event_out.observed <= 1'b1;
                        event_out.error    <= 1'b1;
                        event_out.use_once <= 1'b1;
                    end
                    `CSA_OP_SYS_CMP: begin
                        event_out.valid    <= 1'b1;
                        event_out.observed <= 1'b1;
                        event_out.sys_done <= 1'b1;
                        wait_cmp_r[rid]    <= 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Evict refusal and busy status
    always_ff @(posedge clock) begin
        if (rst) begin
            evict_refused_r <= 1'b0;
            busy_r          <= 1'b0;
        end else if (ce) begin
            evict_refused_r <= core_req && core_evict &&
                               s_ebusy[core_req_id[IW-1:0]];
            busy_r          <= !ds_r[0] || (|wait_cmp_r);
        end
    end

endmodule

// *** bench/csa_agent_chk.sv ***
// Port checks for the snoop response agent
`timescale 1ns/1ps
`include "csa_defines.svh"
module csa_agent_chk
    import csa_pkg::*;
(
    // Clock and reset
    input wire logic          clock,
    input wire logic          rst,
    // Host traffic
    input wire csa_snoop_t    snoop_in,
    input wire csa_h2d_rsp_t  h2d_rsp_in,
    input wire csa_d2h_rsp_t  d2h_rsp_out,
    input wire csa_d2h_data_t d2h_data_out,
    // Core side
    input wire csa_event_t    event_out,
    input wire logic          busy_r
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ------
    // Helpers
    // ------
    // Two beats back to back, then idle
    sequence s_line;
        d2h_data_out.valid [*2] ##1 !d2h_data_out.valid;
    endsequence
    wire fwd = d2h_rsp_out.op inside {`CSA_RSP_SFWDM, `CSA_RSP_IFWDM,
                                      `CSA_RSP_VFWDV};
    wire pull = h2d_rsp_in.op inside {`CSA_OP_PULL, `CSA_OP_OBS_PULL,
                                      `CSA_OP_LOCAL_PULL, `CSA_OP_ERR_PULL};
    wire go = h2d_rsp_in.op == `CSA_OP_GLOBAL_OBS;
    // ------
    // Assertions
    // ------
    AST_RST: assert property (disable iff (1'b0)
        rst |=> !d2h_rsp_out.valid && !d2h_data_out.valid
            && !event_out.valid && !busy_r)
        else $error("reset out");
    AST_SNP_REPLY: assert property (
        $rose(snoop_in.valid) |=> d2h_rsp_out.valid
            && d2h_rsp_out.tag == $past(snoop_in.tag))
        else $error("snoop reply");
    AST_FWD_DATA: assert property (
        d2h_rsp_out.valid && fwd |=>
            (d2h_data_out.tag == $past(d2h_rsp_out.tag)) ##0 s_line)
        else $error("fwd data");
    AST_BYTE_EN: assert property (
        d2h_data_out.valid |-> &d2h_data_out.byte_en)
        else $error("byte en");
    AST_PULL_DATA: assert property (
        $rose(h2d_rsp_in.valid) && pull && !snoop_in.valid |-> ##2
            (d2h_data_out.tag == $past(h2d_rsp_in.data, 2)) ##0 s_line)
        else $error("pull data");
    AST_DISCARD: assert property (
        $rose(h2d_rsp_in.valid) && h2d_rsp_in.op == `CSA_OP_OBS_DISCARD
            |=> !d2h_data_out.valid [*3])
        else $error("discard");
    AST_GO_EVT: assert property (
        $rose(h2d_rsp_in.valid) && go |=> event_out.valid
            && event_out.observed
            && event_out.req_id == $past(h2d_rsp_in.req_id))
        else $error("go event");
    AST_GO_ERR: assert property (
        $rose(h2d_rsp_in.valid) && go
            && h2d_rsp_in.data[3:0] == `CSA_MESI_ERR
            |=> event_out.use_once && event_out.error)
        else $error("go error");
endmodule

bind csa_agent csa_agent_chk u_csa_agent_chk (.clock(clock), .rst(rst),
    .snoop_in(snoop_in), .h2d_rsp_in(h2d_rsp_in),
    .d2h_rsp_out(d2h_rsp_out), .d2h_data_out(d2h_data_out),
    .event_out(event_out), .busy_r(busy_r));

// *** bench/csa_host_model.sv ***
// Host coherency engine model: sends snoops and responses, gathers data
`timescale 1ns/1ps
module csa_host_model
    import csa_pkg::*;
(
    // Clock
    input  wire logic          clock,
    // Device replies and data
    input  wire csa_d2h_rsp_t  d2h_rsp_in,
    input  wire csa_d2h_data_t d2h_data_in,
    // Host messages
    output csa_snoop_t         snoop_out,
    output csa_h2d_rsp_t       rsp_out
);
    int            beats = 0;
    logic [511:0]  line;
    csa_d2h_rsp_t  last_rsp;
    csa_d2h_data_t last_dat;
    initial begin
        snoop_out = '0;
        rsp_out = '0;
    end
    // First beat ends up low
    always @(posedge clock) begin
        if (d2h_rsp_in.valid === 1'b1)
            last_rsp <= d2h_rsp_in;
        if (d2h_data_in.valid === 1'b1) begin
            beats <= beats + 1;
            last_dat <= d2h_data_in;
            line <= {d2h_data_in.data, line[511:256]};
        end
    end
    // Waits for reply and data to drain
    task automatic snoop(input logic [2:0] op, input logic [11:0] tg,
                         input logic [45:0] a);
        @(negedge clock);
        snoop_out <= '{1'b1, op, tg, a};
        @(negedge clock);
        // Idle fields inverted
        snoop_out <= '{1'b0, ~op, ~tg, ~a};
        repeat (4) @(negedge clock);
    endtask
    // Never overlaps an open snoop
    task automatic respond(input logic [3:0] op, input logic [11:0] dt,
                           input logic [11:0] id);
        @(negedge clock);
        rsp_out <= '{1'b1, op, dt, id};
        @(negedge clock);
        rsp_out <= '{1'b0, ~op, ~dt, ~id};
        repeat (4) @(negedge clock);
    endtask
endmodule

// *** bench/csa_agent_bench.sv ***
// Self-checking bench for the snoop response agent
`timescale 1ns/1ps
`include "csa_defines.svh"
module csa_agent_bench;
    import csa_pkg::*;
    logic          clock = 1'b0, rst = 1'b1, core_req = 1'b0, fast = 1'b0;
    logic          core_evict = 1'b0, core_cacheable = 1'b0;
    logic          core_fill = 1'b0, refused, evict_refused_r, busy_r;
    logic [11:0]   core_req_id = '0, tg;
    logic [45:0]   core_addr = '0, a;
    logic [511:0]  core_wdata = '0, d;
    logic [3:0]    ops [4] = '{`CSA_OP_OBS_PULL, `CSA_OP_OBS_DISCARD,
                               `CSA_OP_LOCAL_PULL, `CSA_OP_ERR_PULL};
    csa_snoop_t    snoop_in;
    csa_h2d_rsp_t  h2d_rsp_in;
    csa_d2h_rsp_t  d2h_rsp_out;
    csa_d2h_data_t d2h_data_out;
    csa_event_t    event_out, ev;
    int            fail_count = 0, checked = 0, b0;
    initial forever #10 clock = ~clock;
    // Fill reuses the write data
    csa_agent u_csa_agent (.clock(clock), .rst(rst), .ce(1'b1),
        .snoop_in(snoop_in), .h2d_rsp_in(h2d_rsp_in), .core_req(core_req),
        .core_req_id(core_req_id), .core_addr(core_addr),
        .core_evict(core_evict), .core_cacheable(core_cacheable),
        .core_wdata(core_wdata), .core_fill(core_fill),
        .core_fill_data(core_wdata), .core_fast_obs(fast),
        .d2h_rsp_out(d2h_rsp_out), .d2h_data_out(d2h_data_out),
        .event_out(event_out), .evict_refused_r(evict_refused_r),
        .busy_r(busy_r));
    csa_host_model u_csa_host_model (.clock(clock),
        .d2h_rsp_in(d2h_rsp_out), .d2h_data_in(d2h_data_out),
        .snoop_out(snoop_in), .rsp_out(h2d_rsp_in));
    // Latch one-cycle pulses
    always @(posedge clock) begin
        if (event_out.valid === 1'b1)
            ev <= event_out;
        if (evict_refused_r === 1'b1)
            refused <= 1'b1;
    end
    task automatic check(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic core(input logic [11:0] id, input logic evc, fl);
        @(negedge clock);
        {core_req_id, core_addr, core_evict, core_wdata} = {id, a, evc, d};
        core_cacheable = 1'($urandom);
        core_req = !fl;
        core_fill = fl;
        @(negedge clock);
        core_req = 1'b0;
        core_fill = 1'b0;
    endtask
    // Legal reply to a hit on M
    function automatic logic ok_rsp(input logic [2:0] op, input logic [4:0] r);
        if (op == `CSA_SNP_SHARED)
            return r == `CSA_RSP_SFWDM || r == `CSA_RSP_IFWDM;
        return r == ((op == `CSA_SNP_OWN) ? `CSA_RSP_IFWDM : `CSA_RSP_VFWDV);
    endfunction
    task automatic rnd();
        a = 46'({$urandom, $urandom});
        tg = 12'($urandom);
        for (int i = 0; i < 16; i++)
            d[i*32+:32] = $urandom;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        end_sim();
    end
    initial begin
        void'($urandom(42523));
        repeat (3) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        check(!busy_r && !d2h_rsp_out.valid, "reset");
        for (int k = 1; k <= 3; k++) begin
            rnd();
            core(12'h0, 1'b0, 1'b0);
            core(12'h0, 1'b0, 1'b1);
            u_csa_host_model.respond(`CSA_OP_GLOBAL_OBS, 12'h006, 12'h0);
            check(ev.state === CSA_ST_M, "grant m");
            b0 = u_csa_host_model.beats;
            u_csa_host_model.snoop(3'(k), tg, a);
            check(ok_rsp(3'(k), u_csa_host_model.last_rsp.op), "rsp");
            check(u_csa_host_model.line === d, "fwd data");
            u_csa_host_model.snoop(`CSA_SNP_OWN, ~tg, a);
            check((u_csa_host_model.beats == b0 + 4) == (k == 3), "n");
        end
        rnd();
        refused = 1'b0;
        core(12'h1, 1'b1, 1'b0);
        core(12'h1, 1'b1, 1'b0);
        @(negedge clock);
        check(refused, "second evict");
        u_csa_host_model.snoop(`CSA_SNP_OWN, ~tg, a);
        u_csa_host_model.respond(`CSA_OP_PULL, tg, 12'h1);
        check(u_csa_host_model.last_dat.stale, "stale");
        u_csa_host_model.respond(`CSA_OP_GLOBAL_OBS, 12'h003, 12'h1);
        check(ev.use_once, "use once");
        refused = 1'b0;
        core(12'h1, 1'b1, 1'b0);
        @(negedge clock);
        check(refused === 1'b0, "evict after go and pull");
        rnd();
        core(12'h2, 1'b0, 1'b0);
        foreach (ops[i]) begin
            b0 = u_csa_host_model.beats;
            u_csa_host_model.respond(ops[i], tg, 12'h2);
            check(u_csa_host_model.beats - b0 == ((i == 1) ? 0 : 2), "p");
        end
        check(ev.error, "error pull");
        u_csa_host_model.respond(`CSA_OP_SYS_CMP, 12'h000, 12'h2);
        check(ev.sys_done, "completion");
        u_csa_host_model.respond(`CSA_OP_GLOBAL_OBS, 12'h004, 12'h2);
        check(ev.error && ev.use_once, "go error");
        check(ev.drop_mod === core_cacheable, "drop");
        fast = 1'b1;
        u_csa_host_model.respond(`CSA_OP_LOCAL_OBS, 12'h000, 12'h3);
        check(ev.req_id == 12'h3 && busy_r, "fast go");
        u_csa_host_model.snoop(`CSA_SNP_CUR, tg, ~a);
        check(u_csa_host_model.last_rsp.op === `CSA_RSP_IHITI, "miss");
        end_sim();
    end
endmodule
